// [hw/ccs_pkg.sv]
// package: constants, types and helpers of the clock and power-state controller
`default_nettype none
package ccs_pkg;
    // timing
    localparam int          CLK_MHZ         = 40;
    localparam int          CLK_PERIOD_NS   = 25;
    localparam int          OSC_SETTLE_US   = 100;
    localparam int          SREF_WAIT_NS    = 1000;
    localparam int          CNT_W           = 12;
    localparam logic [11:0] OSC_SETTLE_CYC  = 12'(OSC_SETTLE_US * CLK_MHZ);
    localparam logic [11:0] SREF_WAIT_CYC   =
        12'((SREF_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int          RTC_DIV_DEFAULT = 32768;
    localparam int          RTC_W           = 16;

    // synchroniser bit positions
    localparam int          NSYNC     = 9;
    localparam int          SY_POR    = 0;
    localparam int          SY_PWRFL  = 1;
    localparam int          SY_USER   = 2;
    localparam int          SY_WAKE   = 3;
    localparam int          SY_XT32   = 4;
    localparam int          SY_XTHF   = 5;
    localparam int          SY_OSC_OK = 6;
    localparam int          SY_MLOCK  = 7;
    localparam int          SY_ULOCK  = 8;

    // register map
    localparam logic [7:0]  ADDR_CLKSET              = 8'h00;
    localparam logic [7:0]  ADDR_PWRCTL              = 8'h04;
    localparam logic [7:0]  ADDR_POWER_STATUS_RECORD = 8'h08;
    localparam logic [7:0]  ADDR_RTC_SECONDS         = 8'h0c;

    // clock setting fields
    localparam int          CS_BUS_LSB   = 0;
    localparam int          CS_PER_LSB   = 2;
    localparam int          CS_BUS_GATE  = 4;
    localparam int          CS_PROG_LSB  = 8;
    localparam logic [1:0]  BUS_CODE_RST = 2'h1;
    localparam logic [1:0]  PER_CODE_RST = 2'h0;
    localparam logic [7:0]  PROG_RST     = 8'h00;

    // power control and status fields
    localparam int          PC_HALT   = 0;
    localparam int          PC_STBY   = 1;
    localparam int          SR_ST_LSB = 0;
    localparam int          SR_POR    = 4;
    localparam int          SR_PWRFL  = 5;
    localparam int          SR_USER   = 6;
    localparam int          SR_MLOCK  = 7;
    localparam int          SR_ULOCK  = 8;

    localparam int          HALF_W    = 6;

    typedef enum logic [2:0] {
        ST_RESET,
        ST_STBY,
        ST_WAKE,
        ST_LOCK,
        ST_RUN,
        ST_HALT,
        ST_SREF
    } ccs_state_t;

    // half period of the bus clock in clk cycles: core clock is clk / 2
    function automatic logic [HALF_W-1:0] ccs_bus_half(input logic [1:0] code);
        return HALF_W'(code) + HALF_W'(1);
    endfunction

    function automatic logic [HALF_W-1:0] ccs_per_half(input logic [1:0] bcode,
                                                       input logic [1:0] pcode);
        logic [HALF_W-1:0] b;
        b = ccs_bus_half(bcode);
        case (pcode)
            2'h0:    return b << 1;
            2'h1:    return b << 2;
            default: return b << 3;
        endcase
    endfunction
endpackage
`default_nettype wire

// [hw/ccs_div_if.sv]
// interface: settings and output level of one glitch-free clock divider
`default_nettype none
interface ccs_div_if;
    import ccs_pkg::*;
    logic [HALF_W-1:0] half;
    logic              run;
    logic              clk_lvl;
    modport ctl (output half, output run, input clk_lvl);
    modport div (input half, input run, output clk_lvl);
endinterface
`default_nettype wire

// [hw/ccs_clkdiv.sv]
// module: clock divider that takes new settings only at a period boundary
`default_nettype none
module ccs_clkdiv (
    input  wire logic clk,
    input  wire logic rst_n,
    ccs_div_if.div    dv
);
    import ccs_pkg::*;

    typedef struct packed {
        logic [HALF_W-1:0] cnt;
        logic [HALF_W-1:0] half;
        logic              lvl;
    } ccs_div_st_t;

    ccs_div_st_t r_ff;
    ccs_div_st_t nxt_r;

    always_comb begin
        nxt_r = r_ff;
        if (r_ff.cnt == r_ff.half - HALF_W'(1)) begin
            nxt_r.cnt = '0;
            if (r_ff.lvl) begin
                nxt_r.lvl = 1'b0;
            end else begin
                // only here, after a whole low phase, so no short pulse
                nxt_r.half = (dv.half == '0) ? HALF_W'(1) : dv.half;
                nxt_r.lvl  = dv.run;
            end
        end else begin
            nxt_r.cnt = r_ff.cnt + HALF_W'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r_ff <= '{cnt: '0, half: HALF_W'(1), lvl: 1'b0};
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign dv.clk_lvl = r_ff.lvl;
endmodule
`default_nettype wire

// [hw/ccs_sync3.sv]
// module: three-stage input synchroniser, a change counts once stages 2 and 3 agree
`default_nettype none
module ccs_sync3 (
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire logic [ccs_pkg::NSYNC-1:0]  async_in,
    output logic      [ccs_pkg::NSYNC-1:0]  sync_out
);
    import ccs_pkg::*;

    typedef struct packed {
        logic [NSYNC-1:0] s1;
        logic [NSYNC-1:0] s2;
        logic [NSYNC-1:0] s3;
        logic [NSYNC-1:0] q;
    } ccs_sync_st_t;

    ccs_sync_st_t r_ff;
    ccs_sync_st_t nxt_r;

    always_comb begin
        logic [NSYNC-1:0] agree;
        agree    = ~(r_ff.s2 ^ r_ff.s3);
        nxt_r    = r_ff;
        nxt_r.s1 = async_in;
        nxt_r.s2 = r_ff.s1;
        nxt_r.s3 = r_ff.s2;
        nxt_r.q  = (agree & r_ff.s2) | (~agree & r_ff.q);
    end

    // zero at reset: reset pins read as asserted, locks as not locked
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r_ff <= '0;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign sync_out = r_ff.q;
endmodule
`default_nettype wire

// [hw/ccs_top.sv]
// module: clock, power-state and reset controller top
//
// Function
// - divide slow crystal to 1 Hz tick
// - slow crystal never stops, runs state logic; here state logic runs on clk, slow crystal only feeds the RTC
// - fast crystal feeds PLLs and output divider
// - main PLL gives core, bus, peripheral clocks; here all three are divided from clk
// - bus clock is core divided 1..4
// - bus clock can be gated off
// - peripheral clock is bus divided 2,4,8
// - USB PLL gives fixed 48 MHz clock
// - run state enables all clocks
// - halt stops only core clock until wake
// - standby stops oscillator, disables display
// - any reset input makes system reset
// - power-on reset clears everything
// - other resets spare SDRAM and RTC state
// - SDRAM self-refresh before soft reset
// - leave reset into standby
// - status record holds last reset cause
// - interrupt logic stays alive in low power
//
// Added by the designer: the register addresses and the plain strobed port.
`default_nettype none
module ccs_top #(
    parameter int RTC_DIV = ccs_pkg::RTC_DIV_DEFAULT
) (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        power_on_reset_n,
    input  wire logic        power_fail_reset_n,
    input  wire logic        user_reset_n,
    input  wire logic        wakeup,
    input  wire logic        irq_pending,
    input  wire logic        lf_xtal_clk,
    input  wire logic        hf_xtal_clk,
    input  wire logic        hf_osc_ready,
    input  wire logic        main_pll_lock,
    input  wire logic        usb_pll_lock,
    input  wire logic        sdram_sref_ack,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    output logic             core_clock,
    output logic             bus_clock,
    output logic             periph_clock,
    output logic             usb_clock_enable,
    output logic             prog_clock_out,
    output logic             rtc_tick_1hz,
    output logic             hf_osc_enable,
    output logic             main_pll_enable,
    output logic             usb_pll_enable,
    output logic             lcd_enable,
    output logic             intc_clock_enable,
    output logic             sdram_sref_req,
    output logic             sys_reset_n,
    output logic             keep_reset_n
);
    import ccs_pkg::*;

    typedef struct packed {
        ccs_state_t        state;
        logic [CNT_W-1:0]  cnt;
        logic [1:0]        bus_code;
        logic [1:0]        per_code;
        logic              bus_gate;
        logic [7:0]        prog_half;
        logic [7:0]        prog_act;
        logic [7:0]        prog_cnt;
        logic              prog_lvl;
        logic              sr_por;
        logic              sr_pwrfl;
        logic              sr_user;
        logic [RTC_W-1:0]  rtc_cnt;
        logic [31:0]       rtc_sec;
        logic              rtc_tick;
        logic              xt32_prev;
        logic              xthf_prev;
        logic              hf_osc_en;
        logic              mpll_en;
        logic              upll_en;
        logic              usb_en;
        logic              lcd_en;
        logic              sref_req;
        logic              sys_rst_n;
        logic              keep_rst_n;
        logic [31:0]       rdata;
    } ccs_top_st_t;

    localparam ccs_top_st_t TOP_RST = '{
        state:    ST_RESET,
        cnt:      '0,
        bus_code: BUS_CODE_RST,
        per_code: PER_CODE_RST,
        bus_gate: 1'b0,
        prog_half: PROG_RST,
        prog_act: PROG_RST,
        prog_cnt: '0,
        prog_lvl: 1'b0,
        sr_por:   1'b1,
        sr_pwrfl: 1'b0,
        sr_user:  1'b0,
        rtc_cnt:  '0,
        rtc_sec:  '0,
        rtc_tick: 1'b0,
        xt32_prev: 1'b0,
        xthf_prev: 1'b0,
        hf_osc_en: 1'b0,
        mpll_en:  1'b0,
        upll_en:  1'b0,
        usb_en:   1'b0,
        lcd_en:   1'b0,
        sref_req: 1'b0,
        sys_rst_n: 1'b0,
        keep_rst_n: 1'b0,
        rdata:    '0
    };

    logic [1:0]       rsync_ff;
    logic             rst_n;
    logic [NSYNC-1:0] sy;
    ccs_top_st_t      r_ff;
    ccs_top_st_t      nxt_r;

    ccs_div_if core_if ();
    ccs_div_if bus_if ();
    ccs_div_if per_if ();

    // chip reset released through two flops
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rsync_ff <= 2'h0;
        end else begin
            rsync_ff <= {rsync_ff[0], 1'b1};
        end
    end
    assign rst_n = rsync_ff[1];

    ccs_sync3 u_sync (
        .clk      (clk),
        .rst_n    (rst_n),
        .async_in ({usb_pll_lock, main_pll_lock, hf_osc_ready, hf_xtal_clk,
                    lf_xtal_clk, wakeup, user_reset_n, power_fail_reset_n,
                    power_on_reset_n}),
        .sync_out (sy)
    );

    ccs_clkdiv u_core_div (
        .clk   (clk),
        .rst_n (rst_n),
        .dv    (core_if.div)
    );
    ccs_clkdiv u_bus_div (
        .clk   (clk),
        .rst_n (rst_n),
        .dv    (bus_if.div)
    );
    ccs_clkdiv u_per_div (
        .clk   (clk),
        .rst_n (rst_n),
        .dv    (per_if.div)
    );

    // core clock is clk / 2, the other two follow from the ratio codes
    assign core_if.half = HALF_W'(1);
    assign core_if.run  = (r_ff.state == ST_RUN);
    assign bus_if.half  = ccs_bus_half(r_ff.bus_code);
    assign bus_if.run   = ((r_ff.state == ST_RUN) ||
                           (r_ff.state == ST_HALT)) && !r_ff.bus_gate;
    assign per_if.half  = ccs_per_half(r_ff.bus_code, r_ff.per_code);
    assign per_if.run   = (r_ff.state == ST_RUN) || (r_ff.state == ST_HALT);

    always_comb begin
        logic soft_rst;
        logic wake_ev;
        logic wr_ctl;
        soft_rst = !sy[SY_PWRFL] || !sy[SY_USER];
        wake_ev  = sy[SY_WAKE] || irq_pending;
        wr_ctl   = reg_wr && (reg_addr == ADDR_PWRCTL) && r_ff.sys_rst_n;
        nxt_r           = r_ff;
        nxt_r.rtc_tick  = 1'b0;
        nxt_r.rdata     = '0;
        nxt_r.xt32_prev = sy[SY_XT32];
        nxt_r.xthf_prev = sy[SY_XTHF];

        // counter chain on slow crystal edges, counts in every state
        if (sy[SY_XT32] && !r_ff.xt32_prev) begin
            if (r_ff.rtc_cnt == RTC_W'(RTC_DIV - 1)) begin
                nxt_r.rtc_cnt  = '0;
                nxt_r.rtc_tick = 1'b1;
                nxt_r.rtc_sec  = r_ff.rtc_sec + 32'h1;
            end else begin
                nxt_r.rtc_cnt = r_ff.rtc_cnt + RTC_W'(1);
            end
        end

        // programmable output divider on fast crystal edges
        if (sy[SY_XTHF] && !r_ff.xthf_prev) begin
            if (r_ff.prog_act == '0 ||
                r_ff.prog_cnt == r_ff.prog_act - 8'h1) begin
                nxt_r.prog_cnt = '0;
                if (r_ff.prog_lvl) begin
                    nxt_r.prog_lvl = 1'b0;
                end else begin
                    // new setting only after a full low phase
                    nxt_r.prog_act = r_ff.prog_half;
                    nxt_r.prog_lvl = (r_ff.prog_half != '0);
                end
            end else begin
                nxt_r.prog_cnt = r_ff.prog_cnt + 8'h1;
            end
        end

        // register writes, ignored while the system is held in reset
        if (reg_wr && r_ff.sys_rst_n && reg_addr == ADDR_CLKSET) begin
            nxt_r.bus_code  = reg_wdata[CS_BUS_LSB +: 2];
            nxt_r.per_code  = reg_wdata[CS_PER_LSB +: 2];
            nxt_r.bus_gate  = reg_wdata[CS_BUS_GATE];
            nxt_r.prog_half = reg_wdata[CS_PROG_LSB +: 8];
        end

        // register reads, answered one cycle later
        if (reg_rd) begin
            case (reg_addr)
                ADDR_CLKSET: begin
                    nxt_r.rdata[CS_BUS_LSB +: 2]  = r_ff.bus_code;
                    nxt_r.rdata[CS_PER_LSB +: 2]  = r_ff.per_code;
                    nxt_r.rdata[CS_BUS_GATE]      = r_ff.bus_gate;
                    nxt_r.rdata[CS_PROG_LSB +: 8] = r_ff.prog_half;
                end
                ADDR_PWRCTL, ADDR_POWER_STATUS_RECORD: begin
                    nxt_r.rdata[SR_ST_LSB +: 3] = r_ff.state;
                    nxt_r.rdata[SR_POR]         = r_ff.sr_por;
                    nxt_r.rdata[SR_PWRFL]       = r_ff.sr_pwrfl;
                    nxt_r.rdata[SR_USER]        = r_ff.sr_user;
                    nxt_r.rdata[SR_MLOCK]       = sy[SY_MLOCK];
                    nxt_r.rdata[SR_ULOCK]       = sy[SY_ULOCK];
                end
                ADDR_RTC_SECONDS: begin
                    nxt_r.rdata = r_ff.rtc_sec;
                end
                default: begin
                    nxt_r.rdata = '0;
                end
            endcase
        end

        unique case (r_ff.state)
            ST_RUN: begin
                if (wr_ctl && reg_wdata[PC_STBY]) begin
                    nxt_r.state     = ST_STBY;
                    nxt_r.hf_osc_en = 1'b0;
                    nxt_r.mpll_en   = 1'b0;
                    nxt_r.upll_en   = 1'b0;
                    nxt_r.usb_en    = 1'b0;
                    nxt_r.lcd_en    = 1'b0;
                end else if (wr_ctl && reg_wdata[PC_HALT]) begin
                    nxt_r.state = ST_HALT;
                end
            end
            ST_HALT: begin
                if (wake_ev) begin
                    nxt_r.state = ST_RUN;
                end
            end
            ST_STBY: begin
                if (wake_ev) begin
                    nxt_r.state     = ST_WAKE;
                    nxt_r.hf_osc_en = 1'b1;
                    nxt_r.cnt       = '0;
                end
            end
            ST_WAKE: begin
                if (!sy[SY_OSC_OK]) begin
                    nxt_r.cnt = '0;
                end else if (r_ff.cnt == OSC_SETTLE_CYC - 12'h1) begin
                    nxt_r.state   = ST_LOCK;
                    nxt_r.mpll_en = 1'b1;
                    nxt_r.upll_en = 1'b1;
                end else begin
                    nxt_r.cnt = r_ff.cnt + 12'h1;
                end
            end
            ST_LOCK: begin
                if (sy[SY_MLOCK] && sy[SY_ULOCK]) begin
                    nxt_r.state  = ST_RUN;
                    nxt_r.usb_en = 1'b1;
                    nxt_r.lcd_en = 1'b1;
                end
            end
            ST_SREF: begin
                nxt_r.cnt = r_ff.cnt + 12'h1;
                if (sdram_sref_ack || r_ff.cnt == SREF_WAIT_CYC - 12'h1) begin
                    nxt_r.state     = ST_RESET;
                    nxt_r.sys_rst_n = 1'b0;
                end
            end
            ST_RESET: begin
                if (!soft_rst) begin
                    nxt_r.state      = ST_STBY;
                    nxt_r.sys_rst_n  = 1'b1;
                    nxt_r.keep_rst_n = 1'b1;
                    nxt_r.sref_req   = 1'b0;
                end
            end
        endcase

        // soft reset: self-refresh first, RTC and SDRAM side kept
        if (soft_rst && r_ff.state != ST_SREF && r_ff.state != ST_RESET) begin
            nxt_r.state    = ST_SREF;
            nxt_r.cnt      = '0;
            nxt_r.sref_req = 1'b1;
            nxt_r.sr_por   = 1'b0;
            nxt_r.sr_pwrfl = !sy[SY_PWRFL];
            nxt_r.sr_user  = !sy[SY_USER];
        end
        if (!r_ff.sys_rst_n || nxt_r.state == ST_RESET) begin
            nxt_r.bus_code  = BUS_CODE_RST;
            nxt_r.per_code  = PER_CODE_RST;
            nxt_r.bus_gate  = 1'b0;
            nxt_r.prog_half = PROG_RST;
            nxt_r.hf_osc_en = 1'b0;
            nxt_r.mpll_en   = 1'b0;
            nxt_r.upll_en   = 1'b0;
            nxt_r.usb_en    = 1'b0;
            nxt_r.lcd_en    = 1'b0;
        end

        // power-on reset wins over everything, RTC included
        if (!sy[SY_POR]) begin
            nxt_r = TOP_RST;
            nxt_r.xt32_prev = sy[SY_XT32];
            nxt_r.xthf_prev = sy[SY_XTHF];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r_ff <= TOP_RST;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign reg_rdata         = r_ff.rdata;
    assign core_clock        = core_if.clk_lvl;
    assign bus_clock         = bus_if.clk_lvl;
    assign periph_clock      = per_if.clk_lvl;
    assign usb_clock_enable  = r_ff.usb_en;
    assign prog_clock_out    = r_ff.prog_lvl;
    assign rtc_tick_1hz      = r_ff.rtc_tick;
    assign hf_osc_enable     = r_ff.hf_osc_en;
    assign main_pll_enable   = r_ff.mpll_en;
    assign usb_pll_enable    = r_ff.upll_en;
    assign lcd_enable        = r_ff.lcd_en;
    // interrupt logic clock follows the always-on reset only
    assign intc_clock_enable = r_ff.keep_rst_n;
    assign sdram_sref_req    = r_ff.sref_req;
    assign sys_reset_n       = r_ff.sys_rst_n;
    assign keep_reset_n      = r_ff.keep_rst_n;
endmodule
`default_nettype wire

// [sim/ccs_sva.sv]
// checker: port-level properties of the clock and power-state controller
`default_nettype none
module ccs_sva (
    input wire logic clk,
    input wire logic resetn,
    input wire logic hf_osc_ready,
    input wire logic main_pll_lock,
    input wire logic usb_pll_lock,
    input wire logic core_clock,
    input wire logic periph_clock,
    input wire logic usb_clock_enable,
    input wire logic rtc_tick_1hz,
    input wire logic hf_osc_enable,
    input wire logic usb_pll_enable,
    input wire logic lcd_enable,
    input wire logic intc_clock_enable,
    input wire logic sdram_sref_req,
    input wire logic sys_reset_n,
    input wire logic keep_reset_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence per_high; // shortest periph half period is two cycles
        periph_clock [*2];
    endsequence
    sequence locks_held;
        $past(main_pll_lock, 3) && $past(usb_pll_lock, 3) &&
        $past(hf_osc_ready, 3);
    endsequence
    keep_scope_a: assert property (!keep_reset_n |-> !sys_reset_n)
        else $error("keep domain reset without system reset");
    sref_first_a: assert property ($fell(sys_reset_n) && keep_reset_n
        |-> $past(sdram_sref_req)) else $error("soft reset without refresh");
    per_pulse_a: assert property (disable iff (!resetn || !sys_reset_n)
        $rose(periph_clock) |-> per_high) else $error("periph pulse short");
    core_half_a: assert property (disable iff (!resetn || !sys_reset_n)
        core_clock |=> !core_clock) else $error("core clock not half rate");
    stby_dark_a: assert property (!hf_osc_enable |-> !lcd_enable)
        else $error("display on without oscillator");
    lock_first_a: assert property ($rose(lcd_enable) |-> locks_held)
        else $error("clocks enabled before lock");
    intc_alive_a: assert property (sys_reset_n |-> intc_clock_enable)
        else $error("interrupt clock off");
    tick_pulse_a: assert property (rtc_tick_1hz |=> !rtc_tick_1hz)
        else $error("tick longer than one cycle");
    usb_src_a: assert property (usb_clock_enable |-> usb_pll_enable)
        else $error("usb clock without its pll");
endmodule
bind ccs_top ccs_sva i_ccs_sva (.clk, .resetn, .hf_osc_ready, .main_pll_lock,
    .usb_pll_lock, .core_clock, .periph_clock, .usb_clock_enable, .rtc_tick_1hz,
    .hf_osc_enable, .usb_pll_enable, .lcd_enable, .intc_clock_enable,
    .sdram_sref_req, .sys_reset_n, .keep_reset_n);
`default_nettype wire

// [sim/ccs_far_model.sv]
// far side model: oscillator, both plls and sdram self-refresh answer
`default_nettype none
module ccs_far_model #(
    parameter int SETTLE  = 20,
    parameter int ACK_DLY = 5
) (
    input  wire logic clk,
    input  wire logic hf_osc_enable,
    input  wire logic main_pll_enable,
    input  wire logic usb_pll_enable,
    input  wire logic sdram_sref_req,
    output var logic  hf_osc_ready = 1'h0,
    output var logic  main_pll_lock = 1'h0,
    output var logic  usb_pll_lock = 1'h0,
    output var logic  sdram_sref_ack = 1'h0
);
    timeunit 1ns;
    timeprecision 1ps;
    int oc = 0, mc = 0, uc = 0, sc = 0;
    always @(posedge clk) begin // lock drops at once when enable goes
        oc = hf_osc_enable ? oc + 1 : 0;
        mc = main_pll_enable && hf_osc_ready ? mc + 1 : 0;
        uc = usb_pll_enable && hf_osc_ready ? uc + 1 : 0;
        sc = sdram_sref_req ? sc + 1 : 0;
        hf_osc_ready <= oc > SETTLE;
        main_pll_lock <= mc > SETTLE;
        usb_pll_lock <= uc > SETTLE + 4;
        sdram_sref_ack <= sc > ACK_DLY;
    end
endmodule
`default_nettype wire

// [sim/tb_top.sv]
// testbench: power states, resets, dividers and registers
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import ccs_pkg::*;
    logic        clk = 1'h0, resetn = 1'h0, wakeup = 1'h0, irq_pending = 1'h0;
    logic        power_on_reset_n = 1'h0, power_fail_reset_n = 1'h1;
    logic        user_reset_n = 1'h1, lf_xtal_clk = 1'h0, hf_xtal_clk = 1'h0;
    logic        reg_wr = 1'h0, reg_rd = 1'h0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, rv, r0;
    logic        core_clock, bus_clock, periph_clock, usb_clock_enable;
    logic        prog_clock_out, rtc_tick_1hz, hf_osc_enable, lcd_enable;
    logic        main_pll_enable, usb_pll_enable, intc_clock_enable;
    logic        sdram_sref_req, sys_reset_n, keep_reset_n, hf_osc_ready;
    logic        main_pll_lock, usb_pll_lock, sdram_sref_ack;
    int          failures = 0, n_compared = 0, p, cyc = 0;
    ccs_top #(.RTC_DIV(8)) i_ccs_top (.clk, .resetn, .power_on_reset_n,
        .power_fail_reset_n, .user_reset_n, .wakeup, .irq_pending,
        .lf_xtal_clk, .hf_xtal_clk, .hf_osc_ready, .main_pll_lock,
        .usb_pll_lock, .sdram_sref_ack, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .core_clock, .bus_clock, .periph_clock,
        .usb_clock_enable, .prog_clock_out, .rtc_tick_1hz, .hf_osc_enable,
        .main_pll_enable, .usb_pll_enable, .lcd_enable, .intc_clock_enable,
        .sdram_sref_req, .sys_reset_n, .keep_reset_n);
    ccs_far_model i_ccs_far_model (.clk, .hf_osc_enable, .main_pll_enable,
        .usb_pll_enable, .sdram_sref_req, .hf_osc_ready, .main_pll_lock,
        .usb_pll_lock, .sdram_sref_ack);
    initial forever #12.5 clk = ~clk;
    always @(posedge clk) begin // crystals slowed: one second is 64 cycles
        cyc <= cyc + 1;
        if (cyc % 3 == 0) hf_xtal_clk <= ~hf_xtal_clk;
        if (cyc % 4 == 0) lf_xtal_clk <= ~lf_xtal_clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'h0;
        #1 d = reg_rdata;
    endtask
    task automatic wait_st(input logic [2:0] st);
        int n = 0;
        do begin
            rd(ADDR_POWER_STATUS_RECORD, rv);
            n++;
        end while (rv[2:0] !== st && n < 5000);
        check(32'(rv[2:0]), 32'(st));
    endtask
    task automatic wait_rst(input logic lvl);
        int n = 0;
        while (sys_reset_n !== lvl && n < 300) begin
            @(posedge clk);
            #1 n++;
        end
        check(32'(sys_reset_n), 32'(lvl));
    endtask
    // period in clk cycles between two rises; 0 when stopped
    task automatic meas(input int sel, output int per);
        logic prv = 1'h1, cur;
        int n = 0, r = 0, t0 = 0;
        per = 0;
        while (r < 2 && n < 400) begin
            @(posedge clk);
            #1 n++;
            cur = sel == 0 ? bus_clock : sel == 1 ? periph_clock :
                  sel == 2 ? core_clock : prog_clock_out;
            if (cur && !prv) begin
                r++;
                per = r == 2 ? n - t0 : 0;
                t0 = n;
            end
            prv = cur;
        end
    endtask
    task automatic end_of_test();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        resetn <= 1'h1;
        power_on_reset_n <= 1'h1;
        wait_rst(1'h1);
        wait_st(ST_STBY);
        check(32'(rv[4]), 32'h1);
        rd(ADDR_CLKSET, rv);
        check(rv, 32'h1);
        rd(8'h40, rv);
        check(rv, 32'h0);
        wr(ADDR_PWRCTL, 32'h1);
        wait_st(ST_STBY);
        wakeup <= 1'h1;
        wait_st(ST_RUN);
        wakeup <= 1'h0;
        check(32'({lcd_enable, usb_clock_enable, hf_osc_enable}),
              32'h7);
        rd(ADDR_RTC_SECONDS, r0);
        repeat (639) @(posedge clk);
        rd(ADDR_RTC_SECONDS, rv);
        check(rv - r0, 32'd10);
        for (int b = 0; b < 4; b++) begin
            wr(ADDR_CLKSET, 32'(b + 4 * (b % 3)) | 32'h200);
            repeat (150) @(posedge clk);
            meas(0, p);
            check(32'(p), 32'(2 * (b + 1)));
            meas(1, p);
            check(32'(p), 32'((4 * (b + 1)) << (b % 3)));
        end
        meas(3, p);
        check(32'(p), 32'h18);
        wr(ADDR_CLKSET, 32'h11);
        repeat (150) @(posedge clk);
        meas(0, p);
        check(32'(p), 32'h0);
        wr(ADDR_CLKSET, 32'h1);
        meas(2, p);
        check(32'(p), 32'h2);
        wr(ADDR_PWRCTL, 32'h1);
        wait_st(ST_HALT);
        meas(2, p);
        check(32'(p), 32'h0);
        meas(0, p);
        check(32'(p), 32'h4);
        irq_pending <= 1'h1;
        wait_st(ST_RUN);
        irq_pending <= 1'h0;
        wr(ADDR_PWRCTL, 32'h3);
        wait_st(ST_STBY);
        check(32'({hf_osc_enable, lcd_enable, intc_clock_enable}),
              32'h1);
        irq_pending <= 1'h1;
        wait_st(ST_RUN);
        irq_pending <= 1'h0;
        for (int k = 0; k < 2; k++) begin
            rd(ADDR_RTC_SECONDS, r0);
            user_reset_n <= k[0];
            power_fail_reset_n <= !k[0];
            wait_rst(1'h0);
            check(32'({sdram_sref_req, keep_reset_n}), 32'h3);
            user_reset_n <= 1'h1;
            power_fail_reset_n <= 1'h1;
            wait_rst(1'h1);
            wait_st(ST_STBY);
            check(32'(rv[6:5]), k == 0 ? 32'h2 : 32'h1);
            rd(ADDR_RTC_SECONDS, rv);
            check(32'(rv >= r0), 32'h1);
            wakeup <= 1'h1;
            wait_st(ST_RUN);
            wakeup <= 1'h0;
        end
        power_on_reset_n <= 1'h0;
        wait_rst(1'h0);
        check(32'(keep_reset_n), 32'h0);
        power_on_reset_n <= 1'h1;
        wait_rst(1'h1);
        rd(ADDR_RTC_SECONDS, rv);
        check(32'(rv < 2), 32'h1);
        end_of_test();
    end
    initial begin
        repeat (60000) @(posedge clk);
        failures++;
        end_of_test();
    end
endmodule
`default_nettype wire
